// ### core/nidpr_params.svh
// Register offsets, field positions, reset values for node identity and PHY access
`ifndef NIDPR_PARAMS_SVH
`define NIDPR_PARAMS_SVH
`define NIDPR_OFF_NODE_ID      12'h0E8
`define NIDPR_OFF_PHY_ACC      12'h0EC
`define NIDPR_BUS_INDEX_RST    10'h3FF
`define NIDPR_NODE_VALID_BIT   31
`define NIDPR_ROOT_BIT         30
`define NIDPR_CPG_BIT          27
`define NIDPR_RD_DONE_BIT      31
`define NIDPR_RD_REQ_BIT       15
`define NIDPR_WR_REQ_BIT       14
`endif

// ### core/nidpr_phy_req.sv
// Request sequencer: hands a pending PHY register request to the link-PHY port
module nidpr_phy_req (
  input  wire logic                    clk,
  input  wire logic                    nrst,
  input  wire logic                    rd_pend,
  input  wire logic                    wr_pend,
  input  wire logic [3:0]              addr,
  input  wire logic [7:0]              wdata,
  input  wire logic                    phy_ready,
  output nidpr_pkg::nidpr_phy_req_t    phy_req,
  output logic                         sent
);
  typedef struct packed {
    nidpr_pkg::nidpr_req_state_t st;
    nidpr_pkg::nidpr_phy_req_t   req;
  } nidpr_seq_t;

  nidpr_seq_t s_reg;
  nidpr_seq_t s_next;

  always_comb
  begin
    s_next = s_reg;
    unique case (s_reg.st)
      nidpr_pkg::NIDPR_IDLE:
      begin
        if (rd_pend || wr_pend)
        begin
          s_next.req.valid    = 1'b1;
          s_next.req.is_write = wr_pend;
          s_next.req.addr     = addr;
          s_next.req.data     = wr_pend ? wdata : 8'h00;
          s_next.st           = nidpr_pkg::NIDPR_SEND;
        end
      end
      nidpr_pkg::NIDPR_SEND:
      begin
        if (phy_ready)
        begin
          s_next.req.valid = 1'b0;
          s_next.st        = nidpr_pkg::NIDPR_DONE;
        end
      end
      nidpr_pkg::NIDPR_DONE:
      begin
        s_next.st = nidpr_pkg::NIDPR_IDLE;
      end
      default:
      begin
        s_next = '0;
        s_next.st = nidpr_pkg::NIDPR_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      s_reg    <= '0;
      s_reg.st <= nidpr_pkg::NIDPR_IDLE;
    end
    else
      s_reg <= s_next;
  end

  assign phy_req = s_reg.req;
  assign sent    = (s_reg.st == nidpr_pkg::NIDPR_DONE);
endmodule : nidpr_phy_req

// ### core/nidpr_pkg.sv
// Types shared by the node identity and PHY access block
package nidpr_pkg;
  typedef struct packed {
    logic       valid;
    logic       is_write;
    logic [3:0] addr;
    logic [7:0] data;
  } nidpr_phy_req_t;

  typedef struct packed {
    logic       valid;
    logic [3:0] addr;
    logic [7:0] data;
  } nidpr_phy_resp_t;

  typedef struct packed {
    logic        valid;
    logic        root;
    logic        power_ok;
    logic [5:0]  node;
  } nidpr_selfid_t;

  typedef enum logic [2:0] {
    NIDPR_IDLE = 3'b001,
    NIDPR_SEND = 3'b010,
    NIDPR_DONE = 3'b100
  } nidpr_req_state_t;
endpackage : nidpr_pkg

// ### core/nidpr_top.sv
// Node identity register and PHY register mailbox behind an APB slave
//
// The APB interface to the registers is this design's own decision.
`include "nidpr_params.svh"
module nidpr_top (
  input  wire logic                    CLK,
  input  wire logic                    NRST,
  input  wire logic                    PSEL,
  input  wire logic                    PENABLE,
  input  wire logic                    PWRITE,
  input  wire logic [11:0]             PADDR,
  input  wire logic [31:0]             PWDATA,
  output logic      [31:0]             PRDATA,
  output logic                         PREADY,
  output logic                         PSLVERR,
  input  wire logic                    BUS_RESET,
  input  nidpr_pkg::nidpr_selfid_t     SELFID,
  input  nidpr_pkg::nidpr_phy_resp_t   PHY_RESP,
  input  wire logic                    PHY_REQ_READY,
  output nidpr_pkg::nidpr_phy_req_t    PHY_REQ,
  output logic      [15:0]             NODE_ID,
  output logic                         NODE_ID_VALID
);
  typedef struct packed {
    logic        node_id_valid;
    logic        root;
    logic        cable_power_good;
    logic [9:0]  bus_index;
    logic [5:0]  phys_node_index;
    logic        phy_read_complete;
    logic [3:0]  returned_reg_addr;
    logic [7:0]  returned_reg_value;
    logic        phy_read_request;
    logic        phy_write_request;
    logic [3:0]  target_phy_reg_addr;
    logic [7:0]  phy_write_value;
    logic [31:0] rdata;
  } nidpr_state_t;

  nidpr_state_t s_reg;
  nidpr_state_t s_next;
  logic         req_sent;

  function automatic logic [31:0] node_word(input nidpr_state_t s);
    logic [31:0] w;
    w = 32'h0000_0000;
    w[`NIDPR_NODE_VALID_BIT] = s.node_id_valid;
    w[`NIDPR_ROOT_BIT]       = s.root;
    w[`NIDPR_CPG_BIT]        = s.cable_power_good;
    w[15:0]                  = {s.bus_index, s.phys_node_index};
    return w;
  endfunction : node_word

  function automatic logic [31:0] phy_word(input nidpr_state_t s);
    logic [31:0] w;
    w = 32'h0000_0000;
    w[`NIDPR_RD_DONE_BIT] = s.phy_read_complete;
    w[27:24]              = s.returned_reg_addr;
    w[23:16]              = s.returned_reg_value;
    w[`NIDPR_RD_REQ_BIT]  = s.phy_read_request;
    w[`NIDPR_WR_REQ_BIT]  = s.phy_write_request;
    w[11:8]               = s.target_phy_reg_addr;
    w[7:0]                = s.phy_write_value;
    return w;
  endfunction : phy_word

  nidpr_phy_req u_req (
    .clk       (CLK),
    .nrst      (NRST),
    .rd_pend   (s_reg.phy_read_request),
    .wr_pend   (s_reg.phy_write_request),
    .addr      (s_reg.target_phy_reg_addr),
    .wdata     (s_reg.phy_write_value),
    .phy_ready (PHY_REQ_READY),
    .phy_req   (PHY_REQ),
    .sent      (req_sent)
  );

  logic apb_setup;
  logic apb_wr;
  logic hit_node;
  logic hit_phy;

  assign apb_setup = PSEL && !PENABLE;
  assign apb_wr    = PSEL && PENABLE && PWRITE;
  assign hit_node  = (PADDR == `NIDPR_OFF_NODE_ID);
  assign hit_phy   = (PADDR == `NIDPR_OFF_PHY_ACC);

  always_comb
  begin
    s_next = s_reg;
    // Read data captured in setup phase, stands through access
    if (apb_setup && !PWRITE)
    begin
      if (hit_node)
        s_next.rdata = node_word(s_reg);
      else if (hit_phy)
        s_next.rdata = phy_word(s_reg);
      else
        s_next.rdata = 32'h0000_0000;
    end
    // Request bits drop once the sequencer has sent them
    if (req_sent)
    begin
      s_next.phy_read_request  = 1'b0;
      s_next.phy_write_request = 1'b0;
    end
    if (apb_wr && hit_node)
      s_next.bus_index = PWDATA[15:6];
    if (apb_wr && hit_phy)
    begin
      s_next.target_phy_reg_addr = PWDATA[11:8];
      s_next.phy_write_value     = PWDATA[7:0];
      // A new request is only latched while none is in flight
      if (!s_reg.phy_read_request && !s_reg.phy_write_request)
      begin
        s_next.phy_read_request  = PWDATA[`NIDPR_RD_REQ_BIT];
        s_next.phy_write_request = PWDATA[`NIDPR_WR_REQ_BIT];
      end
      if (PWDATA[`NIDPR_RD_REQ_BIT] || PWDATA[`NIDPR_WR_REQ_BIT])
        s_next.phy_read_complete = 1'b0;
    end
    // Returned transfer wins over a same-cycle clear
    if (PHY_RESP.valid)
    begin
      s_next.phy_read_complete  = 1'b1;
      s_next.returned_reg_addr  = PHY_RESP.addr;
      s_next.returned_reg_value = PHY_RESP.data;
    end
    if (SELFID.power_ok)
      s_next.cable_power_good = 1'b1;
    else
      s_next.cable_power_good = 1'b0;
    if (BUS_RESET)
    begin
      s_next.node_id_valid = 1'b0;
      s_next.root          = SELFID.root;
    end
    else if (SELFID.valid)
    begin
      s_next.node_id_valid   = 1'b1;
      s_next.root            = SELFID.root;
      s_next.phys_node_index = SELFID.node;
    end
  end

  always_ff @(posedge CLK or negedge NRST)
  begin
    if (!NRST)
    begin
      s_reg           <= '0;
      s_reg.bus_index <= `NIDPR_BUS_INDEX_RST;
    end
    else
      s_reg <= s_next;
  end

  assign PRDATA        = s_reg.rdata;
  assign PREADY        = 1'b1;
  assign PSLVERR       = 1'b0;
  assign NODE_ID       = {s_reg.bus_index, s_reg.phys_node_index};
  assign NODE_ID_VALID = s_reg.node_id_valid;
endmodule : nidpr_top

// ### testbench/nidpr_phy_model.sv
// Behavioural PHY layer: takes register requests, returns read transfers
module nidpr_phy_model (
  input  wire logic                  clk,
  input  wire logic                  nrst,
  input  wire logic                  slow,
  input  nidpr_pkg::nidpr_phy_req_t  req,
  output logic                       ready,
  output nidpr_pkg::nidpr_phy_resp_t resp
);
  logic [7:0] regs [16];
  logic [1:0] dly;
  always_ff @(posedge clk or negedge nrst)
    if (!nrst)
    begin
      ready <= 1'b0;
      resp <= '0;
      dly <= 2'h0;
    end
    else
    begin
      // Idle lines toggle so stale values never look valid
      resp <= {1'b0, ~resp.addr, ~resp.data};
      dly <= req.valid ? dly + 2'h1 : 2'h0;
      ready <= req.valid && !ready && (!slow || dly == 2'h3);
      if (req.valid && ready)
      begin
        if (req.is_write)
          regs[req.addr] <= req.data;
        else
          resp <= {1'b1, req.addr, regs[req.addr]};
      end
    end
endmodule : nidpr_phy_model

// ### testbench/nidpr_top_assertions.sv
// Port-level checks for the node identity and PHY access block
`include "nidpr_params.svh"
module nidpr_chk (
  input wire logic                  CLK,
  input wire logic                  NRST,
  input wire logic                  PSEL,
  input wire logic                  PENABLE,
  input wire logic                  PWRITE,
  input wire logic [11:0]           PADDR,
  input wire logic [31:0]           PWDATA,
  input wire logic [31:0]           PRDATA,
  input wire logic                  PREADY,
  input wire logic                  PSLVERR,
  input wire logic                  BUS_RESET,
  input nidpr_pkg::nidpr_selfid_t   SELFID,
  input nidpr_pkg::nidpr_phy_resp_t PHY_RESP,
  input wire logic                  PHY_REQ_READY,
  input nidpr_pkg::nidpr_phy_req_t  PHY_REQ,
  input wire logic [15:0]           NODE_ID,
  input wire logic                  NODE_ID_VALID
);
  logic rd_id;
  logic rd_acc;
  assign rd_id = PSEL && !PENABLE && !PWRITE && PADDR == `NIDPR_OFF_NODE_ID;
  assign rd_acc = PSEL && !PENABLE && !PWRITE && PADDR == `NIDPR_OFF_PHY_ACC;
  default clocking @(posedge CLK); endclocking
  default disable iff (!NRST);
  chk_node_join: assert property (rd_id |=> PRDATA[15:0] == $past(NODE_ID))
    else $error("node id read mismatch");
  chk_node_load: assert property (SELFID.valid && !BUS_RESET |=> NODE_ID[5:0] == $past(SELFID.node))
    else $error("node number not loaded");
  chk_valid_clear: assert property (BUS_RESET && !SELFID.valid |=> !NODE_ID_VALID)
    else $error("valid flag not cleared");
  chk_valid_set: assert property (SELFID.valid && !BUS_RESET |=> NODE_ID_VALID)
    else $error("valid flag not set");
  chk_rsvd_node: assert property (rd_id |=> PRDATA[29:28] == 2'h0 && PRDATA[26:16] == 11'h000)
    else $error("node id reserved bits set");
  chk_rsvd_acc: assert property (rd_acc |=> PRDATA[30:28] == 3'h0 && PRDATA[13:12] == 2'h0)
    else $error("access reserved bits set");
  chk_req_hold: assert property (PHY_REQ.valid && !PHY_REQ_READY |=> $stable(PHY_REQ))
    else $error("request changed before ready");
  chk_req_drop: assert property (PHY_REQ.valid && PHY_REQ_READY |=> !PHY_REQ.valid)
    else $error("request not dropped");
  chk_resp_load: assert property (PHY_RESP.valid ##1 rd_acc |=>
    PRDATA[31:16] == {4'h8, $past(PHY_RESP.addr, 2), $past(PHY_RESP.data, 2)})
    else $error("returned fields mismatch");
endmodule : nidpr_chk
bind nidpr_top nidpr_chk chk_u (.CLK(CLK), .NRST(NRST), .PSEL(PSEL), .PENABLE(PENABLE),
  .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
  .PSLVERR(PSLVERR), .BUS_RESET(BUS_RESET), .SELFID(SELFID), .PHY_RESP(PHY_RESP),
  .PHY_REQ_READY(PHY_REQ_READY), .PHY_REQ(PHY_REQ), .NODE_ID(NODE_ID),
  .NODE_ID_VALID(NODE_ID_VALID));

// ### testbench/tb_node_identity_and_phy_reg_access.sv
// Self-checking bench for the node identity and PHY register mailbox
`include "nidpr_params.svh"
module tb_node_identity_and_phy_reg_access;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0, nrst = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic bus_reset = 1'b0, slow = 1'b0, pready, pslverr, ready, node_valid;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  nidpr_pkg::nidpr_selfid_t   selfid = '0;
  nidpr_pkg::nidpr_phy_resp_t resp;
  nidpr_pkg::nidpr_phy_req_t  req;
  logic [15:0] node_id;
  logic [7:0]  shadow [16] = '{default: 8'h00};
  logic [11:0] last_ret;
  logic [9:0]  bus;
  logic [3:0]  a;
  logic [7:0]  d;
  int err_count = 0;
  int samples_checked = 0;
  always #50 clk = ~clk;
  nidpr_top dut_u (.CLK(clk), .NRST(nrst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .BUS_RESET(bus_reset), .SELFID(selfid), .PHY_RESP(resp), .PHY_REQ_READY(ready),
    .PHY_REQ(req), .NODE_ID(node_id), .NODE_ID_VALID(node_valid));
  nidpr_phy_model phy_u (.clk(clk), .nrst(nrst), .slow(slow), .req(req), .ready(ready),
    .resp(resp));
  task automatic stop_test();
    if (err_count == 0 && samples_checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : stop_test
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      err_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  task automatic apb(input logic w, input logic [11:0] ad, input logic [31:0] wd);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= ad;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    do
      @(posedge clk);
    while (pready !== 1'b1);
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  function automatic logic [31:0] exp_node(input logic v, input nidpr_pkg::nidpr_selfid_t s);
    return {v, s.root, 2'h0, s.power_ok, 11'h000, bus, s.node};
  endfunction : exp_node
  function automatic logic [31:0] exp_acc(input logic dn, input logic [11:0] r,
                                          input logic [11:0] c);
    return {dn, 3'h0, r, 4'h0, c};
  endfunction : exp_acc
  initial
  begin
    void'($urandom(32'hEFCA0A4B));
    repeat (20) @(posedge clk);
    nrst <= 1'b1;
    bus = 10'h3FF;
    apb(1'b0, `NIDPR_OFF_NODE_ID, 32'h0);
    check(rd, exp_node(1'b0, selfid));
    apb(1'b0, `NIDPR_OFF_PHY_ACC, 32'h0);
    check(rd, 32'h0);
    rd = $urandom;
    bus = rd[15:6];
    apb(1'b1, `NIDPR_OFF_NODE_ID, rd);
    apb(1'b0, `NIDPR_OFF_NODE_ID, 32'h0);
    check(rd, exp_node(1'b0, selfid));
    for (int i = 0; i < 2; i++)
    begin
      @(posedge clk);
      selfid <= {1'b1, 2'($urandom), i[0] ? 6'h3F : 6'($urandom)};
      @(posedge clk);
      selfid.valid <= 1'b0;
      apb(1'b0, `NIDPR_OFF_NODE_ID, 32'h0);
      check(rd, exp_node(1'b1, selfid));
      check({16'h0, node_id}, {16'h0, bus, selfid.node});
      check({31'h0, node_valid}, 32'h1);
    end
    @(posedge clk);
    bus_reset <= 1'b1;
    @(posedge clk);
    bus_reset <= 1'b0;
    apb(1'b0, `NIDPR_OFF_NODE_ID, 32'h0);
    check(rd, exp_node(1'b0, selfid));
    check({31'h0, node_valid}, 32'h0);
    last_ret = 12'h000;
    for (int i = 0; i < 8; i++)
    begin
      slow <= 1'($urandom);
      d = 8'($urandom);
      if (!i[0])
        a = 4'($urandom);
      apb(1'b1, `NIDPR_OFF_PHY_ACC, {16'h0, i[0], ~i[0], 2'h0, a, d});
      if (!i[0])
        shadow[a] = d;
      else
        last_ret = {a, shadow[a]};
      do
        apb(1'b0, `NIDPR_OFF_PHY_ACC, 32'h0);
      while (rd[15:14] !== 2'h0);
      apb(1'b0, `NIDPR_OFF_PHY_ACC, 32'h0);
      check(rd, exp_acc(i[0], last_ret, {a, d}));
    end
    stop_test();
  end
  initial
  begin
    repeat (5000) @(posedge clk);
    err_count++;
    stop_test();
  end
endmodule : tb_node_identity_and_phy_reg_access
